/* File: rdc_consts.svh */
// Register offsets, field positions, reset values, masks and code limits
`ifndef RDC_CONSTS_SVH
`define RDC_CONSTS_SVH
`define RDC_ADDR_W 8
`define RDC_ADDR_ISD 8'h80
`define RDC_ADDR_REV 8'h82
`define RDC_ADDR_STAT 8'hF0
`define RDC_ISD_RESET 32'h0000_0000
`define RDC_REV_RESET 32'h0000_0000
`define RDC_ISD_THR_HI 5
`define RDC_ISD_THR_LO 2
`define RDC_ISD_OLI_HI 1
`define RDC_ISD_OLI_LO 0
`define RDC_ISD_MASK 32'h0000_003F
`define RDC_REV_PAR 31
`define RDC_REV_A1_HI 30
`define RDC_REV_A1_LO 27
`define RDC_REV_A2_HI 26
`define RDC_REV_A2_LO 23
`define RDC_REV_BCL_HI 22
`define RDC_REV_BCL_LO 20
`define RDC_REV_KP_HI 19
`define RDC_REV_KP_LO 10
`define RDC_REV_KI_HI 9
`define RDC_REV_KI_LO 0
`define RDC_THR_MAX_CODE 4'hA
`define RDC_BCL_MAX_CODE 3'h6
`define RDC_KP_FRAC_BITS 7
`define RDC_PERMILLE_DIV 26'h00_03E8
`endif

/* File: rdc_pkg.sv */
// Types shared by the reverse drive configuration block
package rdc_pkg;
  typedef enum logic [1:0] {
    RDC_IDLE,
    RDC_REVERSE,
    RDC_OPEN_LOOP
  } rdc_state_t;

  typedef struct packed {
    logic [3:0] thr_code;
    logic [1:0] oli_code;
    logic [3:0] a1_code;
    logic [3:0] a2_code;
    logic [2:0] bcl_code;
  } rdc_codes_t;

  typedef struct packed {
    logic [9:0] thr_permille;
    logic thr_valid;
    logic [11:0] oli_ma;
    logic [16:0] a1_dhz;
    logic [16:0] a2_dhz;
    logic [11:0] bcl_ma;
    logic bcl_valid;
  } rdc_decoded_t;
endpackage

/* File: rdc_decode.sv */
// Decode tables for the reverse drive field codes
`timescale 1ns/1ps
`default_nettype none
`include "rdc_consts.svh"
module rdc_decode (
  input wire rdc_pkg::rdc_codes_t codes,
  output rdc_pkg::rdc_decoded_t dec
);
  // Acceleration table, tenths of Hz/s; code 0 differs between A1 and A2
  function automatic logic [16:0] rdc_accel(input logic [3:0] c, input logic first);
    case (c)
      4'h0: rdc_accel = first ? 17'h0_0001 : 17'h0_0000;
      4'h1: rdc_accel = 17'h0_0005;
      4'h2: rdc_accel = 17'h0_000A;
      4'h3: rdc_accel = 17'h0_0019;
      4'h4: rdc_accel = 17'h0_0032;
      4'h5: rdc_accel = 17'h0_0064;
      4'h6: rdc_accel = 17'h0_00FA;
      4'h7: rdc_accel = 17'h0_01F4;
      4'h8: rdc_accel = 17'h0_02EE;
      4'h9: rdc_accel = 17'h0_03E8;
      4'hA: rdc_accel = 17'h0_09C4;
      4'hB: rdc_accel = 17'h0_1388;
      4'hC: rdc_accel = 17'h0_1D4C;
      4'hD: rdc_accel = 17'h0_2710;
      4'hE: rdc_accel = 17'h0_C350;
      default: rdc_accel = 17'h1_86A0;
    endcase
  endfunction

  always_comb begin
    // Handoff threshold in per mille of max speed
    case (codes.thr_code) // see RULE2
      4'h0: dec.thr_permille = 10'h019;
      4'h1: dec.thr_permille = 10'h032;
      4'h2: dec.thr_permille = 10'h04B;
      4'h3: dec.thr_permille = 10'h064;
      4'h4: dec.thr_permille = 10'h07D;
      4'h5: dec.thr_permille = 10'h096;
      4'h6: dec.thr_permille = 10'h0C8;
      4'h7: dec.thr_permille = 10'h0FA;
      4'h8: dec.thr_permille = 10'h12C;
      4'h9: dec.thr_permille = 10'h190;
      4'hA: dec.thr_permille = 10'h1F4;
      default: dec.thr_permille = 10'h000;
    endcase
    dec.thr_valid = codes.thr_code <= `RDC_THR_MAX_CODE; // see RULE10
    // Open loop current limit in mA
    case (codes.oli_code) // see RULE3
      2'h0: dec.oli_ma = 12'h3A9;
      2'h1: dec.oli_ma = 12'h61A;
      2'h2: dec.oli_ma = 12'h88B;
      default: dec.oli_ma = 12'hC35;
    endcase
    dec.a1_dhz = rdc_accel(codes.a1_code, 1'b1); // see RULE6
    dec.a2_dhz = rdc_accel(codes.a2_code, 1'b0); // see RULE7
    // Active braking bus current limit in mA
    case (codes.bcl_code) // see RULE8
      3'h0: dec.bcl_ma = 12'h138;
      3'h1: dec.bcl_ma = 12'h271;
      3'h2: dec.bcl_ma = 12'h4E2;
      3'h3: dec.bcl_ma = 12'h753;
      3'h4: dec.bcl_ma = 12'h9C4;
      3'h5: dec.bcl_ma = 12'hC35;
      3'h6: dec.bcl_ma = 12'hEA6;
      default: dec.bcl_ma = 12'h000;
    endcase
    dec.bcl_valid = codes.bcl_code <= `RDC_BCL_MAX_CODE;
  end
endmodule
`default_nettype wire

/* File: rdc_top.sv */
// Reverse drive configuration registers and open loop handoff control
// Overview of operation
// RULE1 - In reverse drive, hand off to open loop when speed reaches threshold.
// RULE2 - Threshold codes 0h-Ah give 2.5 to 50 percent of max speed.
// RULE3 - Bits 1-0 select open loop current limit 0.937 A to 3.125 A.
// RULE4 - Reverse drive register sits at offset 82h and resets to zero.
// RULE5 - All reverse drive settings come from that one register. Here the threshold and open loop current codes come from the register at 80h.
// RULE6 - Bit 31 is parity; bits 30-27 are first acceleration coefficient.
// RULE7 - Bits 26-23 are second acceleration coefficient, 0.0 to 10000 Hz/s2.
// RULE8 - Bits 22-20 select braking current limit 0.312 to 3.75 A.
// RULE9 - Bits 19-10 braking proportional gain over 2^7; bits 9-0 integral gain.
// RULE10 - Threshold codes Bh-Fh are unsupported; no handoff is made.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rdc_consts.svh"
module rdc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic reverse_drive_req,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] max_speed,
  output logic open_loop_handoff,
  output logic reverse_active,
  output logic threshold_invalid,
  output logic [15:0] handoff_speed,
  output logic [11:0] reverse_open_loop_current_limit,
  output logic [16:0] reverse_accel_first_coefficient,
  output logic [16:0] reverse_accel_second_coefficient,
  output logic [11:0] braking_current_limit,
  output logic braking_limit_invalid,
  output logic [9:0] braking_loop_proportional_gain,
  output logic [9:0] braking_loop_integral_gain,
  output logic reverse_parity
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] isd_q;
  logic [31:0] isd_d;
  logic [31:0] rev_q;
  logic [31:0] rev_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  rdc_pkg::rdc_state_t state_q;
  rdc_pkg::rdc_state_t state_d;
  logic [15:0] thr_q;
  logic [15:0] thr_d;
  rdc_pkg::rdc_decoded_t out_q;
  rdc_pkg::rdc_decoded_t out_d;
  rdc_pkg::rdc_codes_t codes;
  rdc_pkg::rdc_decoded_t dec;
  logic wr_isd;
  logic wr_rev;
  logic rd_isd;
  logic rd_rev;
  logic rd_stat;
  logic [31:0] stat_word;
  logic speed_at_thr;

  // Speed threshold from max speed and per mille figure
  function automatic logic [15:0] rdc_scale(input logic [15:0] maxv, input logic [9:0] pm);
    logic [25:0] prod;
    prod = 26'(maxv * pm);
    rdc_scale = 16'(prod / `RDC_PERMILLE_DIV);
  endfunction

  // Exact match of the bus address against one offset
  function automatic logic rdc_hit(input logic [7:0] addr, input logic [7:0] target);
    rdc_hit = addr == target;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode
  always_comb begin
    wr_isd = 1'b0;
    wr_rev = 1'b0;
    rd_isd = 1'b0;
    rd_rev = 1'b0;
    rd_stat = 1'b0;
    if (reg_wr && rdc_hit(reg_addr, `RDC_ADDR_ISD)) begin
      wr_isd = 1'b1;
    end else if (reg_wr && rdc_hit(reg_addr, `RDC_ADDR_REV)) begin
      wr_rev = 1'b1;
    end
    if (reg_rd && rdc_hit(reg_addr, `RDC_ADDR_ISD)) begin
      rd_isd = 1'b1;
    end else if (reg_rd && rdc_hit(reg_addr, `RDC_ADDR_REV)) begin
      rd_rev = 1'b1;
    end else if (reg_rd && rdc_hit(reg_addr, `RDC_ADDR_STAT)) begin
      rd_stat = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word from live decode and state
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[0] = state_q == rdc_pkg::RDC_REVERSE;
    stat_word[1] = state_q == rdc_pkg::RDC_OPEN_LOOP;
    stat_word[2] = !dec.thr_valid;
    stat_word[3] = !dec.bcl_valid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_comb begin
    isd_d = isd_q;
    rev_d = rev_q;
    if (wr_isd) begin
      isd_d = reg_wdata & `RDC_ISD_MASK;
    end
    if (wr_rev) begin
      rev_d = reg_wdata; // see RULE5
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      isd_q <= `RDC_ISD_RESET;
      rev_q <= `RDC_REV_RESET; // see RULE4
    end else begin
      isd_q <= isd_d;
      rev_q <= rev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, data stands the cycle after the strobe
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_isd) begin
      rdata_d = isd_q;
    end else if (rd_rev) begin
      rdata_d = rev_q; // see RULE4
    end else if (rd_stat) begin
      rdata_d = stat_word;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction and decode
  always_comb begin
    codes.thr_code = isd_q[`RDC_ISD_THR_HI:`RDC_ISD_THR_LO]; // see RULE1
    codes.oli_code = isd_q[`RDC_ISD_OLI_HI:`RDC_ISD_OLI_LO]; // see RULE3
    codes.a1_code = rev_q[`RDC_REV_A1_HI:`RDC_REV_A1_LO]; // see RULE6
    codes.a2_code = rev_q[`RDC_REV_A2_HI:`RDC_REV_A2_LO]; // see RULE7
    codes.bcl_code = rev_q[`RDC_REV_BCL_HI:`RDC_REV_BCL_LO]; // see RULE8
  end

  rdc_decode u_decode (
    .codes(codes),
    .dec(dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Handoff state machine
  assign speed_at_thr = motor_speed <= thr_q; // see RULE1

  always_comb begin
    state_d = state_q;
    out_d = dec;
    thr_d = rdc_scale(max_speed, dec.thr_permille); // see RULE2
    case (state_q)
      rdc_pkg::RDC_IDLE: begin
        if (reverse_drive_req) begin
          state_d = rdc_pkg::RDC_REVERSE;
        end
      end
      rdc_pkg::RDC_REVERSE: begin
        if (!reverse_drive_req) begin
          state_d = rdc_pkg::RDC_IDLE;
        end else if (out_q.thr_valid && speed_at_thr) begin
          state_d = rdc_pkg::RDC_OPEN_LOOP; // see RULE1 see RULE10
        end
      end
      rdc_pkg::RDC_OPEN_LOOP: begin
        if (!reverse_drive_req) begin
          state_d = rdc_pkg::RDC_IDLE;
        end
      end
      default: state_d = rdc_pkg::RDC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= rdc_pkg::RDC_IDLE;
      thr_q <= 16'h0000;
      out_q <= '0;
    end else begin
      state_q <= state_d;
      thr_q <= thr_d;
      out_q <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign open_loop_handoff = state_q == rdc_pkg::RDC_OPEN_LOOP;
  assign reverse_active = state_q == rdc_pkg::RDC_REVERSE;
  assign threshold_invalid = !out_q.thr_valid;
  assign handoff_speed = thr_q;
  assign reverse_open_loop_current_limit = out_q.oli_ma;
  assign reverse_accel_first_coefficient = out_q.a1_dhz;
  assign reverse_accel_second_coefficient = out_q.a2_dhz;
  assign braking_current_limit = out_q.bcl_ma;
  assign braking_limit_invalid = !out_q.bcl_valid;
  assign braking_loop_proportional_gain = rev_q[`RDC_REV_KP_HI:`RDC_REV_KP_LO]; // see RULE9
  assign braking_loop_integral_gain = rev_q[`RDC_REV_KI_HI:`RDC_REV_KI_LO]; // see RULE9
  assign reverse_parity = rev_q[`RDC_REV_PAR]; // see RULE6
endmodule
`default_nettype wire

/* File: rdc_motor.sv */
// Motor model: speed coasts down while reverse drive is applied
`timescale 1ns/1ps
`default_nettype none
module rdc_motor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spin,
  input wire logic [15:0] start_speed,
  input wire logic [15:0] step,
  output logic [15:0] motor_speed
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      motor_speed <= 16'h0000;
    else if (!spin)
      motor_speed <= start_speed;
    else
      motor_speed <= (motor_speed > step) ? motor_speed - step : 16'h0000;
  end
endmodule
`default_nettype wire

/* File: rdc_top_chk.sv */
// Concurrent checks on the reverse drive configuration block
`timescale 1ns/1ps
`default_nettype none
module rdc_top_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reverse_drive_req,
  input wire logic [15:0] motor_speed,
  input wire logic open_loop_handoff,
  input wire logic reverse_active,
  input wire logic threshold_invalid,
  input wire logic [15:0] handoff_speed,
  input wire logic [11:0] reverse_open_loop_current_limit,
  input wire logic [11:0] braking_current_limit,
  input wire logic braking_limit_invalid,
  input wire logic [9:0] braking_loop_proportional_gain,
  input wire logic [9:0] braking_loop_integral_gain
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic wr_rev;
  logic wr_isd;
  assign wr_rev = reg_wr && reg_addr == 8'h82;
  assign wr_isd = reg_wr && reg_addr == 8'h80;
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  chk_kp_field: assert property (wr_rev |=>
    braking_loop_proportional_gain == $past(reg_wdata[19:10])) else $error("kp field wrong");
  chk_ki_field: assert property (wr_rev |=>
    braking_loop_integral_gain == $past(reg_wdata[9:0])) else $error("ki field wrong");
  chk_brake_code_seven: assert property (wr_rev && reg_wdata[22:20] == 3'h7
    ##1 !wr_rev |=> braking_limit_invalid && braking_current_limit == 12'h000)
    else $error("brake code 7 wrong");
  chk_current_top_code: assert property (wr_isd && reg_wdata[1:0] == 2'h3
    ##1 !wr_isd |=> reverse_open_loop_current_limit == 12'hC35)
    else $error("current limit code 3 wrong");
  chk_drive_exit: assert property (!reverse_drive_req |=>
    !open_loop_handoff && !reverse_active) else $error("state not idle after request drop");
  chk_handoff_entry: assert property (reverse_active && reverse_drive_req
    && !threshold_invalid && motor_speed <= handoff_speed |=> open_loop_handoff)
    else $error("missed handoff");
  chk_invalid_hold: assert property (threshold_invalid && reverse_active |=>
    !open_loop_handoff) else $error("handoff with invalid threshold");
  cover property (open_loop_handoff);
  cover property (threshold_invalid && reverse_active);
  cover property (braking_limit_invalid);
endmodule
bind rdc_top rdc_top_chk u_chk (.*);
`default_nettype wire

/* File: tb_reverse_drive_config.sv */
// Self-checking bench for the reverse drive configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_reverse_drive_config;
  logic core_clk = 0;
  logic rst = 1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic reverse_drive_req = 0;
  logic [15:0] max_speed = 16'h0000;
  logic [15:0] step = 16'h0001;
  logic [31:0] reg_rdata, rev_m;
  logic [15:0] motor_speed, handoff_speed;
  logic open_loop_handoff, reverse_active, threshold_invalid;
  logic braking_limit_invalid, reverse_parity;
  logic [11:0] oli, bcl;
  logic [16:0] a1, a2;
  logic [9:0] kp, ki;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int pm[11] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400, 500};
  int ol[4] = '{937, 1562, 2187, 3125};
  int ac[16] = '{1, 5, 10, 25, 50, 100, 250, 500, 750, 1000, 2500, 5000, 7500, 10000, 50000,
    100000};
  int bc[8] = '{312, 625, 1250, 1875, 2500, 3125, 3750, 0};
  rdc_top DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .max_speed(max_speed),
    .reverse_drive_req(reverse_drive_req), .motor_speed(motor_speed),
    .open_loop_handoff(open_loop_handoff), .reverse_active(reverse_active),
    .threshold_invalid(threshold_invalid), .handoff_speed(handoff_speed),
    .reverse_open_loop_current_limit(oli), .reverse_accel_first_coefficient(a1),
    .reverse_accel_second_coefficient(a2), .braking_current_limit(bcl),
    .braking_limit_invalid(braking_limit_invalid), .braking_loop_proportional_gain(kp),
    .braking_loop_integral_gain(ki), .reverse_parity(reverse_parity));
  rdc_motor u_motor (.core_clk(core_clk), .rst(rst), .spin(reverse_drive_req),
    .start_speed(max_speed), .step(step), .motor_speed(motor_speed));
  always #5 core_clk = ~core_clk;
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic cmp_out(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    cmp_out(g, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == 8'h82)
      rev_m = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    cmp_reg(reg_rdata, e);
  endtask
  initial begin
    logic [31:0] d;
    int hit;
    void'($urandom(54168));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h82, 32'h0000_0000);
    rd(8'h80, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      d = $urandom;
      d[30:20] = {i[3:0], 4'(15 - i), i[2:0]};
      wr(8'h82, d);
      rd(8'h82, d);
      cmp_out(32'(a1), ac[i]);
      cmp_out(32'(a2), (i == 15) ? 0 : ac[15 - i]);
      cmp_out({19'h0, braking_limit_invalid, bcl},
        {19'h0, i[2:0] == 3'h7, 12'(bc[i % 8])});
      cmp_out({11'h0, reverse_parity, kp, ki}, {11'h0, d[31], d[19:0]});
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      max_speed <= 16'(1000 + $urandom % 60000);
      d = $urandom;
      d[5:0] = {i[3:0], i[1:0]};
      wr(8'h80, d);
      rd(8'h80, d & 32'h0000_003F);
      if (i < 11)
        cmp_out(32'(handoff_speed), max_speed * pm[i] / 1000);
      cmp_out(32'(threshold_invalid), 32'(i > 10));
      cmp_out(32'(oli), ol[i % 4]);
      @(posedge core_clk);
      step <= max_speed / 16'd64 + 16'd1;
      reverse_drive_req <= 1'b1;
      hit = 0;
      for (int n = 0; n < 200 && hit == 0; n++) begin
        @(posedge core_clk);
        #1;
        hit = open_loop_handoff;
      end
      cmp_out({30'h0, open_loop_handoff, reverse_active}, (i < 11) ? 2 : 1);
      if (i < 11)
        cmp_out(32'(motor_speed <= handoff_speed), 1);
      rd(8'hF0, (i < 11) ? 32'h0000_000A : 32'h0000_000D);
      @(posedge core_clk);
      reverse_drive_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      cmp_out({30'h0, open_loop_handoff, reverse_active}, 0);
    end
    wr(8'h44, $urandom);
    rd(8'h44, 32'h0000_0000);
    rd(8'h82, rev_m);
    end_sim();
  end
endmodule
`default_nettype wire
